// ===== verilog/ipcw_top.sv
// top: priority configuration registers and window over axi4-lite
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - shared coprocessor level in bits 2..0, resets to level 1
// - level code 0 disables, 1 to 7 are levels, 7 highest
// - without coprocessor shared register ignores writes, reads zero
// - block select bits 7..4 choose group of eight of 128 entries
// - block select zero: window ignores writes, reads zero
// - slot 0 is lowest vector of group, slot 7 highest
// - entry bit 7: 0 main processor, 1 coprocessor
// - irq entry has no target bit, always reads zero
// - without coprocessor target bits ignore ones, read zero
// - entry bits 2..0 hold level, reset enabled at level 1
// - unused channels ignore writes and read zero
// - block f0: slots 2..7 have no storage, read zero
// - block 10: slots 1..4 have no storage, read zero
// - spurious entry fixed, writes ignored, reads 07
// - equal levels: higher vector address takes precedence
module ipcw_top #(
    parameter bit COPROC_PRESENT = 1'b1,
    parameter logic [127:0] USED_CHANNELS = {128{1'b1}}
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output ipcw_pkg::ipcw_entry_t [127:0] entry_cfg_o,
    output logic [2:0] coproc_level_o,
    output logic [6:0] best_entry_o,
    output logic best_valid_o
);
    import ipcw_pkg::*;

    ipcw_entry_t entry [NUM_ENTRIES];
    logic [2:0] coproc_shared_level;
    logic [3:0] config_block_select;
    logic [11:0] aw_addr;
    logic [11:0] wr_idx;
    logic aw_held;
    logic [7:0] w_byte;
    logic w_held;
    logic strb0;
    logic bdone;
    logic wr_fire;

    ////////////////////////////////////////////////////////////////////////
    // entry storage classes
    function automatic logic has_storage(input logic [6:0] idx);
        logic [3:0] blk;
        logic [2:0] slot;
        blk = idx[6:3];
        slot = idx[2:0];
        has_storage = USED_CHANNELS[idx];
        if (blk == 4'h0) has_storage = 1'b0;
        if (blk == BLOCK_TOP && slot >= 3'h2) has_storage = 1'b0;
        if (blk == BLOCK_SPUR && slot >= 3'h1 && slot <= 3'h4) has_storage = 1'b0;
        if (idx == SPURIOUS_ENTRY) has_storage = 1'b0;
    endfunction

    function automatic logic [7:0] entry_read(input logic [6:0] idx, input ipcw_entry_t e);
        entry_read = 8'h00;
        if (idx == SPURIOUS_ENTRY && idx[6:3] != 4'h0) entry_read = SPURIOUS_VALUE;
        else if (has_storage(idx)) begin
            entry_read[TARGET_BIT] = e.target;
            entry_read[LEVEL_LSB +: LEVEL_W] = e.level;
        end
    endfunction

    // register index of a byte address; each register owns one aligned word
    function automatic logic [11:0] word_idx(input logic [11:0] a);
        word_idx = {2'h0, a[11:2]};
    endfunction

    // window slots are the eight indices from the window base upward
    function automatic logic is_window(input logic [11:0] idx);
        is_window = (idx[11:3] == ADDR_WINDOW_BASE[11:3]);
    endfunction

    // unaligned or unmapped byte addresses are refused
    function automatic logic map_ok(input logic [11:0] a);
        logic [11:0] idx;
        idx = word_idx(a);
        map_ok = (a[1:0] == 2'h0) && (idx == ADDR_SHARED_PRIO || idx == ADDR_BLOCK_SEL
                 || is_window(idx));
    endfunction

    // entry as software reads it, packed into the configuration carrier
    function automatic ipcw_entry_t cfg_of(input logic [6:0] idx, input ipcw_entry_t e);
        logic [7:0] b;
        b = entry_read(idx, e);
        cfg_of = {b[TARGET_BIT], b[LEVEL_LSB +: LEVEL_W]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel capture, address and data in either order
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata_i[7:0];
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_held <= 1'b0;
        end
    end

    // registers are byte wide in the low lane of each aligned word
    assign wr_idx = word_idx(aw_addr);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) strb0 <= 1'b0;
        else if (s_axi_wvalid_i && s_axi_wready_o) strb0 <= s_axi_wstrb_i[0];
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end else begin
            s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= AXI_OKAY;
        end else if (aw_held && w_held && !s_axi_bvalid_o && !bdone) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= map_ok(aw_addr) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) bdone <= 1'b0;
        else if (s_axi_bvalid_o && s_axi_bready_i) bdone <= 1'b0;
        else if (aw_held && w_held && !s_axi_bvalid_o) bdone <= 1'b1;
    end

    // refused addresses answer with an error and change nothing
    assign wr_fire = aw_held && w_held && !s_axi_bvalid_o && !bdone && strb0
                     && map_ok(aw_addr);

    ////////////////////////////////////////////////////////////////////////
    // register state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            coproc_shared_level <= SHARED_PRIO_RESET[2:0];
        end else if (wr_fire && wr_idx == ADDR_SHARED_PRIO && COPROC_PRESENT) begin
            coproc_shared_level <= w_byte[LEVEL_LSB +: LEVEL_W];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) config_block_select <= BLOCK_SEL_RESET[7:4];
        else if (wr_fire && wr_idx == ADDR_BLOCK_SEL)
            config_block_select <= w_byte[7:BLOCK_LSB];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENTRIES; gi++) begin : g_entry
            localparam logic [6:0] IDX = 7'(gi);
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    entry[gi].target <= 1'b0;
                    entry[gi].level <= has_storage(IDX) ? RESET_LEVEL : 3'h0;
                end else if (wr_fire && is_window(wr_idx) && has_storage(IDX)
                             && {config_block_select, wr_idx[2:0]} == IDX) begin
                    entry[gi].target <= w_byte[TARGET_BIT] && COPROC_PRESENT
                                        && IDX != IRQ_ENTRY;
                    entry[gi].level <= w_byte[LEVEL_LSB +: LEVEL_W];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read channel
    function automatic logic [7:0] read_byte(input logic [11:0] a);
        logic [11:0] w;
        logic [6:0] idx;
        w = word_idx(a);
        idx = {config_block_select, w[2:0]};
        read_byte = 8'h00;
        if (!map_ok(a)) read_byte = 8'h00;
        else if (w == ADDR_SHARED_PRIO)
            read_byte = COPROC_PRESENT ? {5'h00, coproc_shared_level} : 8'h00;
        else if (w == ADDR_BLOCK_SEL) read_byte = {config_block_select, 4'h0};
        else if (is_window(w) && config_block_select != 4'h0)
            read_byte = entry_read(idx, entry[idx]);
    endfunction

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= AXI_OKAY;
        end else if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b0;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h000000, read_byte(s_axi_araddr_i)};
            s_axi_rresp_o <= map_ok(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
        end else begin
            s_axi_arready_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs and equal-level precedence
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) coproc_level_o <= SHARED_PRIO_RESET[2:0];
        else coproc_level_o <= COPROC_PRESENT ? coproc_shared_level : 3'h0;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            entry_cfg_o <= '0;
        end else begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                entry_cfg_o[i] <= cfg_of(7'(i), entry[i]);
            end
        end
    end

    // highest level wins; ties go to the higher index since ">=" scans upward
    logic [6:0] next_best;
    logic [2:0] best_lvl;
    always_comb begin
        next_best = 7'h00;
        best_lvl = 3'h0;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            if (entry_cfg_o[i].level != 3'h0 && entry_cfg_o[i].level >= best_lvl) begin
                best_lvl = entry_cfg_o[i].level;
                next_best = 7'(i);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            best_entry_o <= 7'h00;
            best_valid_o <= 1'b0;
        end else begin
            best_entry_o <= next_best;
            best_valid_o <= best_lvl != 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_spur_fixed;
        @(posedge clk_sys_i) disable iff (rst_i)
        !rst_i |=> entry_cfg_o[SPURIOUS_ENTRY] == 4'h7;
    endproperty
    a_spur_fixed: assert property (p_spur_fixed) else $error("spurious entry not 07");

    property p_irq_target;
        @(posedge clk_sys_i) disable iff (rst_i)
        !entry[IRQ_ENTRY].target;
    endproperty
    a_irq_target: assert property (p_irq_target) else $error("irq target set");

    property p_shared_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        !(wr_fire && wr_idx == ADDR_SHARED_PRIO) |=> $stable(coproc_shared_level);
    endproperty
    a_shared_hold: assert property (p_shared_hold) else $error("shared level moved");

    property p_blk0_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_axi_arvalid_i && s_axi_arready_o && is_window(word_idx(s_axi_araddr_i))
        && config_block_select == 4'h0 |=> s_axi_rdata_o == 32'h0;
    endproperty
    a_blk0_zero: assert property (p_blk0_zero) else $error("block zero read nonzero");

    property p_top_empty;
        @(posedge clk_sys_i) disable iff (rst_i)
        entry[7'h7a].level == 3'h0 && entry[7'h7f].level == 3'h0;
    endproperty
    a_top_empty: assert property (p_top_empty) else $error("block f0 hole stored");

    property p_spur_hole;
        @(posedge clk_sys_i) disable iff (rst_i)
        entry[7'h09].level == 3'h0 && entry[7'h0c].level == 3'h0;
    endproperty
    a_spur_hole: assert property (p_spur_hole) else $error("block 10 hole stored");

    property p_rd_latency;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read answer late");

    property p_best_valid;
        @(posedge clk_sys_i) disable iff (rst_i)
        best_valid_o |-> best_entry_o == $past(next_best)
            && $past(entry_cfg_o[next_best].level) != 3'h0;
    endproperty
    a_best_valid: assert property (p_best_valid) else $error("best on disabled");

    sequence s_wr_pair;
        aw_held && w_held && !s_axi_bvalid_o && !bdone;
    endsequence
    sequence s_wr_answer;
        s_axi_bvalid_o && bdone;
    endsequence
    property p_wr_answer;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_wr_pair |=> s_wr_answer;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");

    property p_bare_level;
        @(posedge clk_sys_i) disable iff (rst_i)
        !COPROC_PRESENT && !$past(rst_i)
        |-> coproc_level_o == 3'h0 && !entry_cfg_o[7'h21].target;
    endproperty
    a_bare_level: assert property (p_bare_level) else $error("coprocessor field live");
endmodule // ipcw_top
`default_nettype wire

// ===== pkg/ipcw_pkg.sv
// package: register map, field layout and reset values of the priority config window
package ipcw_pkg;
    localparam logic [11:0] ADDR_SHARED_PRIO = 12'h126;
    localparam logic [11:0] ADDR_BLOCK_SEL = 12'h127;
    localparam logic [11:0] ADDR_WINDOW_BASE = 12'h128;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 3;
    localparam int TARGET_BIT = 7;
    localparam int BLOCK_LSB = 4;
    localparam int NUM_ENTRIES = 128;
    localparam int WINDOW_SLOTS = 8;
    localparam logic [2:0] RESET_LEVEL = 3'h1;
    localparam logic [7:0] SHARED_PRIO_RESET = 8'h01;
    localparam logic [7:0] BLOCK_SEL_RESET = 8'h00;
    localparam logic [7:0] SPURIOUS_VALUE = 8'h07;
    localparam logic [6:0] IRQ_ENTRY = 7'h79;
    localparam logic [6:0] SPURIOUS_ENTRY = 7'h08;
    localparam logic [3:0] BLOCK_TOP = 4'hf;
    localparam logic [3:0] BLOCK_SPUR = 4'h1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic target;
        logic [2:0] level;
    } ipcw_entry_t;
endpackage

// ===== tb/ipcw_host_model.sv
// host bus model: axi4-lite master with byte write and read tasks
`timescale 1ns/10ps
`default_nettype none
module ipcw_host_model (
    input wire logic clk_i,
    output logic [11:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [11:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    initial begin
        awaddr_o = 12'h000;
        awvalid_o = 1'b0;
        wdata_o = 32'h0;
        wstrb_o = 4'h0;
        wvalid_o = 1'b0;
        bready_o = 1'b0;
        araddr_o = 12'h000;
        arvalid_o = 1'b0;
        rready_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one byte write in lane 0; each channel held until its own ready
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        awaddr_o <= a;
        awvalid_o <= 1'b1;
        wdata_o <= {24'h0, d};
        wstrb_o <= 4'h1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            if (bvalid_i && bready_o) begin
                r = bresp_i;
                bready_o <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        while (!done) begin
            @(posedge clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            if (rvalid_i && rready_o) begin
                d = rdata_i;
                r = rresp_i;
                rready_o <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule // ipcw_host_model
`default_nettype wire

// ===== tb/tb_ipcw_top.sv
// testbench: register window scenarios over axi4-lite
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch %s expected %h seen %h", nm, e, a); end end
module tb_ipcw_top;
    import ipcw_pkg::*;
    logic clk_sys_i, rst_i, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, best_valid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] coproc_level;
    logic [6:0] best_entry;
    ipcw_entry_t [127:0] entry_cfg;
    int n_mismatch = 0;
    int n_tests = 0;
    // reduced build: no coprocessor, entry 0x20 unused
    localparam logic [127:0] USED_N = ~(128'h1 << 32);
    logic awvalid_n, awready_n, wvalid_n, wready_n, bvalid_n, bready_n;
    logic arvalid_n, arready_n, rvalid_n, rready_n;
    logic [11:0] awaddr_n, araddr_n;
    logic [31:0] wdata_n, rdata_n;
    logic [3:0] wstrb_n;
    logic [1:0] bresp_n, rresp_n;
    logic [2:0] coproc_level_n;
    ipcw_entry_t [127:0] entry_cfg_n;
    bit use_nc = 1'b0;
    ipcw_top ipcw_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .entry_cfg_o(entry_cfg), .coproc_level_o(coproc_level),
        .best_entry_o(best_entry), .best_valid_o(best_valid));
    ipcw_host_model ipcw_host_model_i (.clk_i(clk_sys_i), .awaddr_o(awaddr),
        .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
        .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
        .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
        .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    ipcw_top #(.COPROC_PRESENT(1'b0), .USED_CHANNELS(USED_N)) ipcw_top_nc_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr_n),
        .s_axi_awvalid_i(awvalid_n), .s_axi_awready_o(awready_n), .s_axi_wdata_i(wdata_n),
        .s_axi_wstrb_i(wstrb_n), .s_axi_wvalid_i(wvalid_n), .s_axi_wready_o(wready_n),
        .s_axi_bresp_o(bresp_n), .s_axi_bvalid_o(bvalid_n), .s_axi_bready_i(bready_n),
        .s_axi_araddr_i(araddr_n), .s_axi_arvalid_i(arvalid_n), .s_axi_arready_o(arready_n),
        .s_axi_rdata_o(rdata_n), .s_axi_rresp_o(rresp_n), .s_axi_rvalid_o(rvalid_n),
        .s_axi_rready_i(rready_n), .entry_cfg_o(entry_cfg_n), .coproc_level_o(coproc_level_n),
        .best_entry_o(), .best_valid_o());
    ipcw_host_model ipcw_host_model_nc_i (.clk_i(clk_sys_i), .awaddr_o(awaddr_n),
        .awvalid_o(awvalid_n), .awready_i(awready_n), .wdata_o(wdata_n), .wstrb_o(wstrb_n),
        .wvalid_o(wvalid_n), .wready_i(wready_n), .bresp_i(bresp_n), .bvalid_i(bvalid_n),
        .bready_o(bready_n), .araddr_o(araddr_n), .arvalid_o(arvalid_n), .arready_i(arready_n),
        .rdata_i(rdata_n), .rresp_i(rresp_n), .rvalid_i(rvalid_n), .rready_o(rready_n));
    ////////////////////////////////////////////////////////////////////////////////
    // offsets are register indices; byte address is four times that
    function automatic logic [11:0] ba(input logic [11:0] idx);
        return idx << 2;
    endfunction
    task automatic wr8(input logic [11:0] idx, input logic [7:0] d);
        logic [1:0] r;
        if (use_nc) ipcw_host_model_nc_i.wr(ba(idx), d, r);
        else ipcw_host_model_i.wr(ba(idx), d, r);
        `CHK("bresp", AXI_OKAY, r)
    endtask
    task automatic rd8(input logic [11:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        if (use_nc) ipcw_host_model_nc_i.rd(ba(idx), d, r);
        else ipcw_host_model_i.rd(ba(idx), d, r);
        `CHK("rresp", AXI_OKAY, r)
        `CHK("rdata", {24'h0, e}, d)
    endtask
    task automatic t_reset();
        rd8(ADDR_SHARED_PRIO, SHARED_PRIO_RESET);
        rd8(ADDR_BLOCK_SEL, BLOCK_SEL_RESET);
        `CHK("coproc_level", RESET_LEVEL, coproc_level)
        `CHK("best_entry", SPURIOUS_ENTRY, best_entry)
        wr8(ADDR_WINDOW_BASE + 12'h3, 8'h86);
        rd8(ADDR_WINDOW_BASE + 12'h3, 8'h00);
    endtask
    task automatic t_shared();
        for (int i = 0; i < 8; i++) begin
            wr8(ADDR_SHARED_PRIO, 8'hf8 | 8'(i));
            rd8(ADDR_SHARED_PRIO, 8'(i));
            `CHK("coproc_level", 3'(i), coproc_level)
        end
    endtask
    task automatic t_window();
        wr8(ADDR_BLOCK_SEL, 8'hef);
        rd8(ADDR_BLOCK_SEL, 8'he0);
        rd8(ADDR_WINDOW_BASE + 12'h5, 8'h01);
        for (int s = 0; s < 8; s++) wr8(ADDR_WINDOW_BASE + 12'(s), {s[0], 4'h0, 3'(s)});
        for (int s = 0; s < 8; s++) begin
            rd8(ADDR_WINDOW_BASE + 12'(s), {s[0], 4'h0, 3'(s)});
            `CHK("entry_cfg", {s[0], 3'(s)}, entry_cfg[112 + s])
        end
        `CHK("best_entry", 7'h77, best_entry)
        `CHK("best_valid", 1'b1, best_valid)
    endtask
    task automatic t_fixed();
        logic [31:0] d;
        logic [1:0] r;
        wr8(ADDR_BLOCK_SEL, 8'hf0);
        wr8(ADDR_WINDOW_BASE + 12'h1, 8'h86);
        rd8(ADDR_WINDOW_BASE + 12'h1, 8'h06);
        `CHK("irq entry", 4'h6, entry_cfg[IRQ_ENTRY])
        wr8(ADDR_WINDOW_BASE + 12'h2, 8'h03);
        rd8(ADDR_WINDOW_BASE + 12'h2, 8'h00);
        rd8(ADDR_WINDOW_BASE + 12'h7, 8'h00);
        wr8(ADDR_BLOCK_SEL, 8'h10);
        wr8(ADDR_WINDOW_BASE, 8'h81);
        rd8(ADDR_WINDOW_BASE, SPURIOUS_VALUE);
        wr8(ADDR_WINDOW_BASE + 12'h1, 8'h05);
        rd8(ADDR_WINDOW_BASE + 12'h1, 8'h00);
        rd8(ADDR_WINDOW_BASE + 12'h4, 8'h00);
        rd8(ADDR_WINDOW_BASE + 12'h5, 8'h01);
        ipcw_host_model_i.rd(12'h000, d, r);
        `CHK("unmapped rresp", AXI_SLVERR, r)
        ipcw_host_model_i.wr(ba(ADDR_BLOCK_SEL) + 12'h1, 8'h30, r);
        `CHK("unaligned bresp", AXI_SLVERR, r)
        rd8(ADDR_BLOCK_SEL, 8'h10);
    endtask
    // reduced build: shared level and target bits absent, one channel unused
    task automatic t_bare();
        use_nc = 1'b1;
        wr8(ADDR_SHARED_PRIO, 8'h05);
        rd8(ADDR_SHARED_PRIO, 8'h00);
        `CHK("coproc_level_n", 3'h0, coproc_level_n)
        wr8(ADDR_BLOCK_SEL, 8'h40);
        wr8(ADDR_WINDOW_BASE, 8'h83);
        rd8(ADDR_WINDOW_BASE, 8'h00);
        `CHK("entry_cfg_n", 4'h0, entry_cfg_n[32])
        wr8(ADDR_WINDOW_BASE + 12'h1, 8'h85);
        rd8(ADDR_WINDOW_BASE + 12'h1, 8'h05);
        `CHK("entry_cfg_n", 4'h5, entry_cfg_n[33])
        use_nc = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_shared();
        t_window();
        t_fixed();
        t_bare();
        end_of_test();
    end
endmodule // tb_ipcw_top
`default_nettype wire
